// ---- bench/wdt_top_checker.sv ----
/* wdt_top_checker: port-level assertions for wdt_top.
   Assumes the one-wait-cycle Avalon answer of wdt_top. */
`timescale 1ns/1ps
module wdt_top_checker
#(
    parameter int ADDR_W = 17
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    input  wire logic              waitrequest,
    input  wire logic [31:0]       readdata,
    input  wire logic              sys_rst_in,
    input  wire logic              periodic_irq,
    input  wire logic              sys_reset_req
);
    logic [14:0] idx;

    // register index from the byte address
    assign idx = address[16:2];

    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);

    ////////////////////////////////////////////////////////////////////////
    // an accepted write to one register, and an accepted read
    sequence wr_s(logic [14:0] r);
        write && !waitrequest && idx == r;
    endsequence
    sequence rd_s;
        read && !waitrequest;
    endsequence

    ////////////////////////////////////////////////////////////////////////
    bus_answer_a:
    assert property ((read || write) && waitrequest |-> ##[1:2] !waitrequest)
        else $error("access not answered");
    bus_one_a:
    assert property (!waitrequest |=> waitrequest)
        else $error("waitrequest low too long");
    read_high_a:
    assert property (rd_s |-> readdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
    resv_zero_a:
    assert property (rd_s ##0 (idx == wdt_pkg::IDX_PIRQ_CTRL ||
        idx == wdt_pkg::IDX_DOG_CTRL) |-> readdata[5:3] == 3'h0)
        else $error("reserved or check bits read nonzero");
    key_bad_a:
    assert property (wr_s(wdt_pkg::IDX_SVC_KEY) ##0
        (writedata[7:0] != wdt_pkg::KEY_ARM &&
         writedata[7:0] != wdt_pkg::KEY_CLEAR) |-> ##[1:3] sys_reset_req)
        else $error("bad key gave no reset");
    check_bad_a:
    assert property (wr_s(wdt_pkg::IDX_DOG_CTRL) ##0
        writedata[5:3] != wdt_pkg::CHECK_PAT |-> ##[1:3] sys_reset_req)
        else $error("bad check bits gave no reset");
    reset_pulse_a:
    assert property (sys_reset_req |=> !sys_reset_req)
        else $error("reset request longer than one cycle");
    irq_off_a:
    assert property (wr_s(wdt_pkg::IDX_PIRQ_CTRL) ##0
        !writedata[wdt_pkg::PEN_BIT] |-> ##2 !periodic_irq)
        else $error("request kept after enable cleared");
    sys_clear_a:
    assert property (sys_rst_in |-> ##2 !periodic_irq)
        else $error("request kept over system reset");
endmodule // wdt_top_checker

bind wdt_top wdt_top_checker #(.ADDR_W(ADDR_W)) chk
(
    .clk(clk), .rst_n(rst_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .waitrequest(waitrequest),
    .readdata(readdata), .sys_rst_in(sys_rst_in),
    .periodic_irq(periodic_irq), .sys_reset_req(sys_reset_req)
);

// ---- bench/wdt_top_test.sv ----
/* wdt_top_test: register-level bench for wdt_top over Avalon-MM.
   Assumes a free-running dog clock; every wait is bounded. */
`timescale 1ns/1ps
module wdt_top_test;
    logic        clk = 1'b0;
    logic        rst_n = 1'b0;
    logic [16:0] address = 17'h0;
    logic        read = 1'b0;
    logic        write = 1'b0;
    logic [31:0] writedata = 32'h0;
    logic        waitrequest;
    logic [31:0] readdata;
    logic        dog_clock = 1'b0;
    logic        high_voltage_prog_indication = 1'b0;
    logic        sys_rst_in = 1'b0;
    logic        irq_ack = 1'b0;
    logic        periodic_irq;
    logic        sys_reset_req;
    logic        dclk_on = 1'b0;
    logic [1:0]  dclk_div = 2'h0;
    logic [7:0]  a, b, c;
    int          fails = 0;
    int          n_compared = 0;
    int          rst_seen = 0;
    int          n;
    int          divs[6] = '{4, 16, 64, 128, 256, 512};

    wdt_top #(.ADDR_W(17)) uut
    (
        .clk(clk), .rst_n(rst_n), .address(address), .read(read),
        .write(write), .writedata(writedata), .waitrequest(waitrequest),
        .readdata(readdata), .dog_clock(dog_clock),
        .high_voltage_prog_indication(high_voltage_prog_indication),
        .sys_rst_in(sys_rst_in), .irq_ack(irq_ack),
        .periodic_irq(periodic_irq), .sys_reset_req(sys_reset_req)
    );

    ////////////////////////////////////////////////////////////////////////
    // clock, dog clock of eight clk periods, reset request counter
    always #50 clk = ~clk;
    always @(posedge clk)
    begin
        if (dclk_on)
        begin
            dclk_div <= dclk_div + 2'h1;
            if (dclk_div == 2'h3)
                dog_clock <= ~dog_clock;
        end
        if (sys_reset_req === 1'b1)
            rst_seen <= rst_seen + 1;
    end

    ////////////////////////////////////////////////////////////////////////
    task automatic wrap_up();
        $display("compared %0d, mismatches %0d", n_compared, fails);
        if (fails == 0 && n_compared > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask

    task automatic chk(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp)
        begin
            fails++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    // one access; request held until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [14:0] i,
                       input logic [7:0] d, output logic [7:0] q);
        int k;
        @(posedge clk);
        address   <= {i, 2'h0};
        writedata <= {24'h0, d};
        read      <= !wr;
        write     <= wr;
        k = 0;
        do
        begin
            @(posedge clk);
            k++;
        end
        while (waitrequest !== 1'b0 && k < 50);
        q = readdata[7:0];
        read  <= 1'b0;
        write <= 1'b0;
        if (k >= 50)
        begin
            fails++;
            wrap_up();
        end
    endtask

    task automatic wr(input logic [14:0] i, input logic [7:0] d);
        logic [7:0] x;
        bus(1'b1, i, d, x);
    endtask

    task automatic rd(input logic [14:0] i, output logic [7:0] x);
        bus(1'b0, i, 8'h0, x);
    endtask

    task automatic rdc(input logic [14:0] i, input logic [7:0] e);
        logic [7:0] x;
        bus(1'b0, i, 8'h0, x);
        chk({8'h0, x}, {8'h0, e});
    endtask

    // bounded wait for a level; the count is edges waited
    task automatic wait_hi(ref logic s, output int cnt);
        cnt = 0;
        do
        begin
            @(posedge clk);
            cnt++;
        end
        while (s !== 1'b1 && cnt < 5000);
        if (cnt >= 5000)
        begin
            fails++;
            wrap_up();
        end
    endtask

    task automatic ack();
        irq_ack <= 1'b1;
        @(posedge clk);
        irq_ack <= 1'b0;
    endtask

    ////////////////////////////////////////////////////////////////////////
    initial
    begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        // reset values, read-only counter, key reads control
        rdc(wdt_pkg::IDX_TICK_CNT, 8'h00);
        rdc(wdt_pkg::IDX_PIRQ_CTRL, 8'h00);
        rdc(15'h7022, 8'h00);
        wr(wdt_pkg::IDX_DOG_CNT, 8'hFF);
        rdc(wdt_pkg::IDX_DOG_CNT, 8'h00);
        wr(wdt_pkg::IDX_DOG_CTRL, 8'h2F);
        rdc(wdt_pkg::IDX_SVC_KEY, 8'h07);
        // flag and enable set by software with no tap running yet
        wr(wdt_pkg::IDX_PIRQ_CTRL, 8'hFB);
        rdc(wdt_pkg::IDX_PIRQ_CTRL, 8'hC3);
        chk({15'h0, periodic_irq}, 16'h0);
        wr(wdt_pkg::IDX_PIRQ_CTRL, 8'h00);
        rdc(wdt_pkg::IDX_PIRQ_CTRL, 8'h00);
        // two steps in 2048 clk; three cycles belong to the read
        dclk_on <= 1'b1;
        rd(wdt_pkg::IDX_TICK_CNT, a);
        repeat (2045) @(posedge clk);
        rd(wdt_pkg::IDX_TICK_CNT, b);
        chk({8'h0, b - a}, 16'h2);
        wr(wdt_pkg::IDX_TICK_CNT, 8'h5A);
        rdc(wdt_pkg::IDX_TICK_CNT, 8'h00);
        // first two requests absorb any edge from switching the rate
        for (int s = 0; s < 6; s++)
        begin
            wr(wdt_pkg::IDX_PIRQ_CTRL, 8'h40 | s[7:0]);
            repeat (2)
            begin
                wait_hi(periodic_irq, n);
                ack();
            end
            wait_hi(periodic_irq, n);
            chk(16'(n + 1), 16'(divs[s] * 8));
            ack();
        end
        rdc(wdt_pkg::IDX_PIRQ_CTRL, 8'hC5);
        wait_hi(periodic_irq, n);
        wr(wdt_pkg::IDX_PIRQ_CTRL, 8'h05);
        repeat (2) @(posedge clk);
        n = 0;
        repeat (4200)
        begin
            if (periodic_irq !== 1'b0)
                n++;
            @(posedge clk);
        end
        chk(16'(n), 16'h0);
        // lone AAh does nothing; 55h 55h AAh clears the counter
        wr(wdt_pkg::IDX_DOG_CTRL, 8'h28);
        repeat (400) @(posedge clk);
        rd(wdt_pkg::IDX_DOG_CNT, a);
        wr(wdt_pkg::IDX_SVC_KEY, 8'hAA);
        rd(wdt_pkg::IDX_DOG_CNT, b);
        chk({15'h0, b < a}, 16'h0);
        wr(wdt_pkg::IDX_SVC_KEY, 8'h55);
        wr(wdt_pkg::IDX_SVC_KEY, 8'h55);
        wr(wdt_pkg::IDX_SVC_KEY, 8'hAA);
        rd(wdt_pkg::IDX_DOG_CNT, c);
        chk({15'h0, c > 8'h1}, 16'h0);
        chk(16'(rst_seen), 16'h0);
        // unserviced: 257 ticks of 8 clk, tick phase unknown
        wait_hi(sys_reset_req, n);
        chk({15'h0, n < 2040 || n > 2064}, 16'h0);
        rdc(wdt_pkg::IDX_DOG_CTRL, 8'h80);
        // outside system reset keeps the flag, clears the rest
        wr(wdt_pkg::IDX_PIRQ_CTRL, 8'h43);
        sys_rst_in <= 1'b1;
        @(posedge clk);
        sys_rst_in <= 1'b0;
        rdc(wdt_pkg::IDX_DOG_CTRL, 8'h80);
        rdc(wdt_pkg::IDX_PIRQ_CTRL, 8'h00);
        rdc(wdt_pkg::IDX_TICK_CNT, 8'h00);
        wr(wdt_pkg::IDX_DOG_CTRL, 8'h28);
        rdc(wdt_pkg::IDX_DOG_CTRL, 8'h00);
        // a wrong key, then wrong check bits, each force a reset
        for (int k = 0; k < 2; k++)
        begin
            n = rst_seen;
            if (k == 0)
                wr(wdt_pkg::IDX_SVC_KEY, 8'h23);
            else
                wr(wdt_pkg::IDX_DOG_CTRL, 8'h20);
            repeat (4) @(posedge clk);
            chk(16'(rst_seen - n), 16'h1);
            rdc(wdt_pkg::IDX_DOG_CTRL, 8'h80);
            wr(wdt_pkg::IDX_DOG_CTRL, 8'h28);
        end
        // prescale 100 steps the dog counter every 64 clk: ten in 640
        wr(wdt_pkg::IDX_DOG_CTRL, 8'h2C);
        rd(wdt_pkg::IDX_DOG_CNT, a);
        repeat (637) @(posedge clk);
        rd(wdt_pkg::IDX_DOG_CNT, b);
        chk({8'h0, b - a}, 16'hA);
        // disable bit holds the counter only with the indication set
        high_voltage_prog_indication <= 1'b1;
        wr(wdt_pkg::IDX_DOG_CTRL, 8'h68);
        rd(wdt_pkg::IDX_DOG_CNT, a);
        repeat (200) @(posedge clk);
        rd(wdt_pkg::IDX_DOG_CNT, b);
        chk({8'h0, b - a}, 16'h0);
        high_voltage_prog_indication <= 1'b0;
        repeat (200) @(posedge clk);
        rd(wdt_pkg::IDX_DOG_CNT, c);
        chk({15'h0, c == b}, 16'h0);
        wrap_up();
    end
endmodule // wdt_top_test

// ---- design/wdt_pkg.sv ----
/*
 * wdt_pkg: register indices, field positions, reset values, key codes
 * and the check pattern for the watchdog / periodic interrupt block.
 * Assumes an 8-bit register view placed in the low byte of a 32-bit
 * Avalon-MM word, one aligned word per register.
 */
package wdt_pkg;

    // register indices; byte address is four times the index
    localparam logic [14:0] IDX_TICK_CNT  = 15'h7021;
    localparam logic [14:0] IDX_DOG_CNT   = 15'h7023;
    localparam logic [14:0] IDX_SVC_KEY   = 15'h7025;
    localparam logic [14:0] IDX_PIRQ_CTRL = 15'h7027;
    localparam logic [14:0] IDX_DOG_CTRL  = 15'h7029;

    // periodic_irq_ctrl fields
    localparam int PFLAG_BIT = 7;
    localparam int PEN_BIT   = 6;
    localparam int PSEL_LSB  = 0;

    // dog_ctrl fields
    localparam int DFLAG_BIT = 7;
    localparam int DDIS_BIT  = 6;
    localparam int DCHK_LSB  = 3;
    localparam int DPS_LSB   = 0;

    // reset values
    localparam logic [7:0] TICK_CNT_RST = 8'h00;
    localparam logic [7:0] DOG_CNT_RST  = 8'h00;
    localparam logic [2:0] PSEL_RST     = 3'h0;
    localparam logic [2:0] DPS_RST      = 3'h0;

    // service key codes and check pattern
    localparam logic [7:0] KEY_ARM    = 8'h55;
    localparam logic [7:0] KEY_CLEAR  = 8'hAA;
    localparam logic [2:0] CHECK_PAT  = 3'h5;
    localparam logic [7:0] CNT_TOP    = 8'hFF;

    // free-running prescaler width
    localparam int PRESC_W = 7;

endpackage

// ---- design/wdt_presc.sv ----
/*
 * wdt_presc: synchronises the watchdog clock pin, turns its rising
 * edge into a one-cycle tick and runs the 7-bit free-running
 * prescaler. Assumes the pin is far slower than clk.
 */
`timescale 1ns/1ps
module wdt_presc
(
    input  wire logic  clk,
    input  wire logic  rst_n,
    input  wire logic  dog_clock,
    wdt_tap_if.src     tap
);

    typedef struct packed {
        logic                        s1;
        logic                        s2;
        logic                        s3;
        logic [wdt_pkg::PRESC_W-1:0] cnt;
    } wdt_presc_st_t;

    wdt_presc_st_t state_q;
    wdt_presc_st_t state_d;
    logic          ones_run;

    ////////////////////////////////////////////////////////////////////
    // tick and carries: carry[i] marks an overflow of divide 2**(i+1);
    // a running and keeps every select a single constant-width bit
    always_comb
    begin
        tap.tick = state_q.s2 & ~state_q.s3;
        ones_run = tap.tick;
        for (int i = 0; i < wdt_pkg::PRESC_W; i++)
        begin
            ones_run     = ones_run & state_q.cnt[i];
            tap.carry[i] = ones_run;
        end
    end

    // s1 feeds only s2; the edge is taken between s2 and s3
    always_comb
    begin
        state_d    = state_q;
        state_d.s1 = dog_clock;
        state_d.s2 = state_q.s1;
        state_d.s3 = state_q.s2;
        if (tap.clr)
        begin
            state_d.cnt = '0;
        end
        else if (tap.tick)
        begin
            state_d.cnt = state_q.cnt + 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= '0;
        end
        else
        begin
            state_q <= state_d;
        end
    end

endmodule // wdt_presc

// ---- design/wdt_tap_if.sv ----
/*
 * wdt_tap_if: carries the watchdog clock tick and the prescaler
 * overflow pulses from the prescaler to the register block, and the
 * system clear back to the prescaler. One clock domain throughout.
 */
`timescale 1ns/1ps
interface wdt_tap_if;
    logic                        tick;
    logic [wdt_pkg::PRESC_W-1:0] carry;
    logic                        clr;

    modport src (output tick, output carry, input clr);
    modport dst (input tick, input carry, output clr);
endinterface

// ---- design/wdt_top.sv ----
/*
 * wdt_top: watchdog counter, service key logic, check-bit monitor and
 * periodic interrupt generator behind an Avalon-MM slave.
 * Assumes sys_rst_in, hv_prog and irq_ack come from logic on clk, and
 * that dog_clock is a free pin that is synchronised here.
 */
// Overview of operation
// - tap overflow sets flag; software set silent
// - 8-bit periodic counter steps on /128
// - periodic counter runs in all run modes
// - any write clears periodic counter
// - clearing counter leaves prescaler alone
// - 8-bit dog counter at prescale rate
// - reset one counter tick after overflow
// - valid key clears counter, keeps prescaler
// - dog counter read-only, zero after reset
// - 55h arms, following AAh clears
// - other key value resets the system
// - key reads return dog control
// - flag cleared by 0; irqs continue anyway
// - enable zero drops pending, blocks requests
// - slow rates also use periodic counter
// - one request per overflow leading edge
// - reserved control bits ignored, read zero
// - rate select picks clock divider
// - check bits must equal 101
// - dog reset sets flag; others keep
// - prescale field selects dog divider
// - disable works only with high voltage
`timescale 1ns/1ps
module wdt_top
#(
    parameter int ADDR_W = 17
)
(
    input  wire logic              clk,
    input  wire logic              rst_n,
    input  wire logic [ADDR_W-1:0] address,
    input  wire logic              read,
    input  wire logic              write,
    input  wire logic [31:0]       writedata,
    output logic                   waitrequest,
    output logic [31:0]            readdata,
    input  wire logic              dog_clock,
    input  wire logic              high_voltage_prog_indication,
    input  wire logic              sys_rst_in,
    input  wire logic              irq_ack,
    output logic                   periodic_irq,
    output logic                   sys_reset_req
);

    // the highest index needs seventeen byte-address bits
    if (ADDR_W < 17)
    begin : g_addr_chk
        $error("wdt_top: ADDR_W must be at least 17");
    end

    typedef struct packed {
        logic       waitreq;
        logic [7:0] rdata;
        logic [7:0] tick_cnt;
        logic [7:0] dog_cnt;
        logic       dog_ovf;
        logic       armed;
        logic       pflag;
        logic       pen;
        logic [2:0] psel;
        logic       dflag;
        logic       ddis;
        logic [2:0] dchk;
        logic [2:0] dps;
        logic       irq;
        logic       rst_req;
    } wdt_st_t;

    localparam wdt_st_t ST_RST = '{
        waitreq:  1'b1,
        rdata:    8'h00,
        tick_cnt: wdt_pkg::TICK_CNT_RST,
        dog_cnt:  wdt_pkg::DOG_CNT_RST,
        dog_ovf:  1'b0,
        armed:    1'b0,
        pflag:    1'b0,
        pen:      1'b0,
        psel:     wdt_pkg::PSEL_RST,
        dflag:    1'b0,
        ddis:     1'b0,
        dchk:     wdt_pkg::CHECK_PAT,
        dps:      wdt_pkg::DPS_RST,
        irq:      1'b0,
        rst_req:  1'b0
    };

    wdt_st_t state_q;
    wdt_st_t state_d;

    wdt_tap_if tap ();

    ////////////////////////////////////////////////////////////////////
    // prescaler and pin synchroniser
    wdt_presc u_presc
    (
        .clk       (clk),
        .rst_n     (rst_n),
        .dog_clock (dog_clock),
        .tap       (tap.src)
    );

    assign tap.clr = state_q.rst_req | sys_rst_in;

    ////////////////////////////////////////////////////////////////////
    // tap selection
    logic       tap_hit;
    logic       dog_tick;
    logic [7:0] ctrl_rd;
    logic [7:0] rd_mux;
    logic [14:0] idx;

    assign idx = address[16:2];

    always_comb
    begin
        case (state_q.psel)
            3'h0: tap_hit = tap.carry[1];
            3'h1: tap_hit = tap.carry[3];
            3'h2: tap_hit = tap.carry[5];
            3'h3: tap_hit = tap.carry[6];
            3'h4: tap_hit = tap.carry[6] & state_q.tick_cnt[0];
            3'h5: tap_hit = tap.carry[6] & (&state_q.tick_cnt[1:0]);
            3'h6: tap_hit = tap.carry[6] & (&state_q.tick_cnt[3:0]);
            3'h7: tap_hit = tap.carry[6] & (&state_q.tick_cnt[6:0]);
            default: tap_hit = 1'b0;
        endcase
        case (state_q.dps)
            3'h0: dog_tick = tap.tick;
            3'h1: dog_tick = tap.tick;
            3'h2: dog_tick = tap.carry[0];
            3'h3: dog_tick = tap.carry[1];
            3'h4: dog_tick = tap.carry[2];
            3'h5: dog_tick = tap.carry[3];
            3'h6: dog_tick = tap.carry[4];
            3'h7: dog_tick = tap.carry[5];
            default: dog_tick = 1'b0;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // read data; check bits always read back as zero
    always_comb
    begin
        ctrl_rd = {state_q.dflag, state_q.ddis, 3'h0, state_q.dps};
        case (idx)
            wdt_pkg::IDX_TICK_CNT:  rd_mux = state_q.tick_cnt;
            wdt_pkg::IDX_DOG_CNT:   rd_mux = state_q.dog_cnt;
            wdt_pkg::IDX_SVC_KEY:   rd_mux = ctrl_rd;
            wdt_pkg::IDX_PIRQ_CTRL: rd_mux = {state_q.pflag, state_q.pen,
                                              3'h0, state_q.psel};
            wdt_pkg::IDX_DOG_CTRL:  rd_mux = ctrl_rd;
            default:                rd_mux = 8'h00;
        endcase
    end

    ////////////////////////////////////////////////////////////////////
    // next state
    logic       wr_take;
    logic       dog_on;
    logic       ovf_fire;
    logic       bad_key;
    logic       chk_bad;
    logic       fire;
    logic [7:0] wd;

    always_comb
    begin
        state_d = state_q;
        state_d.rst_req = 1'b0;
        wr_take = 1'b0;
        ovf_fire = 1'b0;
        bad_key = 1'b0;
        wd = writedata[7:0];

        // bus: answer one cycle after the request, act on the
        // edge where the master sees waitrequest low
        if (state_q.waitreq && (read || write))
        begin
            state_d.waitreq = 1'b0;
            state_d.rdata = rd_mux;
        end
        else if (!state_q.waitreq)
        begin
            state_d.waitreq = 1'b1;
            wr_take = write;
        end

        if (tap.carry[6])
        begin
            state_d.tick_cnt = state_q.tick_cnt + 8'h01;
        end

        dog_on = !(state_q.ddis && high_voltage_prog_indication);
        if (dog_on && dog_tick)
        begin
            if (state_q.dog_ovf)
            begin
                ovf_fire = 1'b1;
            end
            else
            begin
                state_d.dog_cnt = state_q.dog_cnt + 8'h01;
                state_d.dog_ovf = (state_q.dog_cnt == wdt_pkg::CNT_TOP);
            end
        end

        if (wr_take)
        begin
            case (idx)
                wdt_pkg::IDX_TICK_CNT:
                begin
                    state_d.tick_cnt = wdt_pkg::TICK_CNT_RST;
                end
                wdt_pkg::IDX_DOG_CNT:
                begin
                    state_d.dog_cnt = state_d.dog_cnt;
                end
                wdt_pkg::IDX_SVC_KEY:
                begin
                    if (wd == wdt_pkg::KEY_ARM)
                    begin
                        state_d.armed = 1'b1;
                    end
                    else if (wd == wdt_pkg::KEY_CLEAR)
                    begin
                        if (state_q.armed)
                        begin
                            state_d.dog_cnt = wdt_pkg::DOG_CNT_RST;
                            state_d.dog_ovf = 1'b0;
                            state_d.armed = 1'b0;
                            ovf_fire = 1'b0;
                        end
                    end
                    else
                    begin
                        bad_key = 1'b1;
                    end
                end
                wdt_pkg::IDX_PIRQ_CTRL:
                begin
                    state_d.pflag = wd[wdt_pkg::PFLAG_BIT];
                    state_d.pen = wd[wdt_pkg::PEN_BIT];
                    state_d.psel = wd[wdt_pkg::PSEL_LSB +: 3];
                    if (!wd[wdt_pkg::PEN_BIT])
                    begin
                        state_d.irq = 1'b0;
                    end
                end
                wdt_pkg::IDX_DOG_CTRL:
                begin
                    state_d.dflag = wd[wdt_pkg::DFLAG_BIT];
                    state_d.ddis = wd[wdt_pkg::DDIS_BIT];
                    state_d.dchk = wd[wdt_pkg::DCHK_LSB +: 3];
                    state_d.dps = wd[wdt_pkg::DPS_LSB +: 3];
                end
                default:
                begin
                    state_d.armed = state_d.armed;
                end
            endcase
        end

        // acknowledge first so a same-cycle overflow still wins
        if (irq_ack)
        begin
            state_d.irq = 1'b0;
        end
        if (tap_hit)
        begin
            state_d.pflag = 1'b1;
            if (state_d.pen)
            begin
                state_d.irq = 1'b1;
            end
        end

        chk_bad = (state_q.dchk != wdt_pkg::CHECK_PAT);
        fire = ovf_fire | bad_key | chk_bad;

        if (fire || sys_rst_in)
        begin
            state_d.tick_cnt = ST_RST.tick_cnt;
            state_d.dog_cnt = ST_RST.dog_cnt;
            state_d.dog_ovf = 1'b0;
            state_d.armed = 1'b0;
            state_d.pflag = 1'b0;
            state_d.pen = 1'b0;
            state_d.psel = ST_RST.psel;
            state_d.ddis = 1'b0;
            state_d.dchk = ST_RST.dchk;
            state_d.dps = ST_RST.dps;
            state_d.irq = 1'b0;
            state_d.dflag = state_d.dflag | fire;
            state_d.rst_req = fire;
        end
    end

    ////////////////////////////////////////////////////////////////////
    // state register
    always_ff @(posedge clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state_q <= ST_RST;
        end
        else
        begin
            state_q <= state_d;
        end
    end

    // outputs come straight from the state register
    assign waitrequest   = state_q.waitreq;
    assign readdata      = {24'h000000, state_q.rdata};
    assign periodic_irq  = state_q.irq;
    assign sys_reset_req = state_q.rst_req;

endmodule // wdt_top
